// >>> core/dsm_pkg.sv
// Notes on behaviour
// - operands widened to 17 bits, sign or zero
// - 33-bit product sign-extended to 40 bits
// - fractional 1.31 product, integer passes unscaled
// - shared multiplier: byte 16-bit, word 32-bit results
// - target accumulator is both source and destination
// - add and load data arrive pre-scaled
// - zero on one input, true/complement other
// - add carry in low, subtract carry in high (borrow inactive) complemented
// - guard flag set when bits 39:32 differ
// - newly set guard flag plus enable traps
// - clip flag sticky, only software clears it
// - clip means bit 31 or bit 39 overflow
// - saturation off plus wrap enable traps on clip
// - status shows OR of guards and clips
// - super mode clamps to 9.31 extremes, sets clip
// - normal mode clamps to 1.31 extremes, sets clip
// - normal saturation never sets guard flags
// - saturation off wraps freely, clip still set
// - saturation uses result, flags, enables, width select
// - multiply and saturation modes from core control
// - accumulator add, subtract and negate supported
// - squared difference takes difference from ALU
// - width select one super, zero normal
// - format select one integer, zero fractional
// - signedness select one unsigned, zero signed
package dsm_pkg;
   localparam int ACC_W  = 40;
   localparam int OPND_W = 16;
   localparam int MUL_W  = 33;
   localparam int GUARD_LO = 32;
   localparam int NORM_TOP = 31;
   localparam int BYTE_W   = 8;
   localparam int HALF_W   = 16;
   // register byte addresses
   localparam logic [4:0] ADR_CTRL    = 5'h00;
   localparam logic [4:0] ADR_TRAP    = 5'h04;
   localparam logic [4:0] ADR_STAT    = 5'h08;
   localparam logic [4:0] ADR_ACCUM_A_LO = 5'h0C;
   localparam logic [4:0] ADR_ACCUM_A_HI = 5'h10;
   localparam logic [4:0] ADR_ACCUM_B_LO = 5'h14;
   localparam logic [4:0] ADR_ACCUM_B_HI = 5'h18;
   localparam logic [4:0] ADR_MCU     = 5'h1C;
   // core_control_reg fields
   localparam int CTL_INT     = 0;
   localparam int CTL_RND     = 1;
   localparam int CTL_WIDTH   = 4;
   localparam int CTL_MEMCLIP = 5;
   localparam int CTL_CLIPB   = 6;
   localparam int CTL_CLIPA   = 7;
   localparam int CTL_SIGN    = 12;
   localparam logic [15:0] CTRL_RESET = 16'h0020;
   localparam logic [15:0] CTRL_MASK  = 16'h10F3;
   // trap enable fields
   localparam int TRP_GA   = 0;
   localparam int TRP_GB   = 1;
   localparam int TRP_WRAP = 2;
   localparam logic [15:0] TRAP_MASK = 16'h0007;
   // status fields
   localparam int ST_GA   = 15;
   localparam int ST_GB   = 14;
   localparam int ST_CA   = 13;
   localparam int ST_CB   = 12;
   localparam int ST_GANY = 11;
   localparam int ST_CANY = 10;
   localparam logic [ACC_W-1:0] SUPER_MAX = 40'h7F_FFFF_FFFF;
   localparam logic [ACC_W-1:0] SUPER_MIN = 40'h80_0000_0000;
   localparam logic [ACC_W-1:0] NORM_MAX  = 40'h00_7FFF_FFFF;
   localparam logic [ACC_W-1:0] NORM_MIN  = 40'hFF_8000_0000;
   typedef enum logic [3:0] {
      OP_NOP      = 4'h0,
      OP_MPY      = 4'h1,
      OP_MPY_NEG  = 4'h2,
      OP_MAC      = 4'h3,
      OP_MSC      = 4'h4,
      OP_LOAD     = 4'h5,
      OP_ADD_DATA = 4'h6,
      OP_ADD_ACC  = 4'h7,
      OP_SUB_ACC  = 4'h8,
      OP_NEG      = 4'h9,
      OP_CLR      = 4'hA,
      OP_SQD      = 4'hB,
      OP_SQD_ACC  = 4'hC,
      OP_MCU_MUL  = 4'hD
   } dsm_op_t;
endpackage : dsm_pkg

// >>> core/dsm_engine.sv
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
module dsm_engine
   import dsm_pkg::*;
(
   // clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // wishbone slave
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [4:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // instruction decoder
   input  wire logic              op_valid_i,
   input  wire logic [3:0]        op_i,
   input  wire logic              acc_sel_i,
   input  wire logic [OPND_W-1:0] opnd_x_i,
   input  wire logic [OPND_W-1:0] opnd_y_i,
   input  wire logic [ACC_W-1:0]  shifted_data_i,
   input  wire logic              mcu_byte_i,
   input  wire logic              mcu_x_signed_i,
   input  wire logic              mcu_y_signed_i,
   // results and events
   output logic      [31:0]       mcu_prod_o,
   output logic                   mcu_prod_valid_o,
   output logic      [ACC_W-1:0]  acc_a_o,
   output logic      [ACC_W-1:0]  acc_b_o,
   output logic                   trap_o,
   output logic                   round_style_o,
   output logic                   mem_write_clip_enable_o
);

   function automatic logic [16:0] ext17(input logic [15:0] v, input logic uns);
      ext17 = {(uns ? 1'b0 : v[15]), v};
   endfunction : ext17

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] sel, input logic [15:0] msk);
      logic [15:0] m;
      m = old;
      if (sel[0]) m[7:0] = nw[7:0];
      if (sel[1]) m[15:8] = nw[15:8];
      merge16 = m & msk;
   endfunction : merge16

   function automatic logic all_same(input logic [8:0] v, input logic top_only);
      all_same = top_only ? ((v[8:1] == 8'h00) || (v[8:1] == 8'hFF))
                          : ((v == 9'h000) || (v == 9'h1FF));
   endfunction : all_same

   logic [15:0]      core_control_reg;
   logic [15:0]      trap_en_reg;
   logic [ACC_W-1:0] accum_a_reg;
   logic [ACC_W-1:0] accum_b_reg;
   logic             accum_a_guard_overflow_reg;
   logic             accum_b_guard_overflow_reg;
   logic             accum_a_clip_flag_reg;
   logic             accum_b_clip_flag_reg;
   logic             ack_reg;
   logic [31:0]      dat_reg;
   logic [31:0]      mcu_prod_reg;
   logic             mcu_valid_reg;
   logic             trap_reg;

   dsm_op_t          op;
   logic             int_mode;
   logic             mult_sign_select;
   logic             clip_width_select;
   logic             clip_en;
   logic [16:0]      mul_a;
   logic [16:0]      mul_b;
   logic [33:0]      prod34;
   logic [MUL_W-1:0] scaled;
   logic [ACC_W-1:0] prod40;
   logic [31:0]      mcu_next;
   logic [ACC_W-1:0] tgt;
   logic [ACC_W-1:0] other;
   logic [ACC_W-1:0] src;
   logic [ACC_W-1:0] b_data;
   logic [ACC_W-1:0] b_eff;
   logic [ACC_W-1:0] sum40;
   logic [ACC_W-1:0] result;
   logic             src_zero;
   logic             subtract;
   logic             ovf39;
   logic             true_neg;
   logic             over31;
   logic             clip_set;
   logic             guard_next;
   logic             pass;
   logic             trap_next;
   logic             bus_req;
   logic             wr_stb;
   logic             clr_a;
   logic             clr_b;
   logic [31:0]      rd_word;

   assign op                = dsm_op_t'(op_i);
   assign int_mode          = core_control_reg[CTL_INT];
   assign mult_sign_select  = core_control_reg[CTL_SIGN];
   assign clip_width_select = core_control_reg[CTL_WIDTH];
   assign tgt   = acc_sel_i ? accum_b_reg : accum_a_reg;
   assign other = acc_sel_i ? accum_a_reg : accum_b_reg;
   assign clip_en = acc_sel_i ? core_control_reg[CTL_CLIPB]
                              : core_control_reg[CTL_CLIPA];
   assign pass = ce_i && op_valid_i && (op != OP_NOP) && (op != OP_MCU_MUL);

   // one multiplier serves both engine and mcu; the squared difference
   // arrives as the alu difference on the x operand
   always_comb begin
      if (op == OP_MCU_MUL) begin
         mul_a = mcu_byte_i ? {9'h000, opnd_x_i[BYTE_W-1:0]}
                            : ext17(opnd_x_i, !mcu_x_signed_i);
         mul_b = mcu_byte_i ? {9'h000, opnd_y_i[BYTE_W-1:0]}
                            : ext17(opnd_y_i, !mcu_y_signed_i);
      end else if (op == OP_SQD || op == OP_SQD_ACC) begin
         mul_a = ext17(opnd_x_i, mult_sign_select);
         mul_b = mul_a;
      end else begin
         mul_a = ext17(opnd_x_i, mult_sign_select);
         mul_b = ext17(opnd_y_i, mult_sign_select);
      end
      prod34 = $signed(mul_a) * $signed(mul_b);
      scaled = int_mode ? prod34[MUL_W-1:0] : {prod34[MUL_W-2:0], 1'b0};
      prod40 = {{(ACC_W-MUL_W){scaled[MUL_W-1]}}, scaled};
      mcu_next = mcu_byte_i ? {16'h0000, prod34[HALF_W-1:0]} : prod34[31:0];
   end

   // adder operand steering
   always_comb begin
      src_zero = 1'b0;
      subtract = 1'b0;
      b_data   = prod40;
      unique case (op)
         OP_MPY, OP_SQD: src_zero = 1'b1;
         OP_MPY_NEG: begin
            src_zero = 1'b1;
            subtract = 1'b1;
         end
         OP_MAC, OP_SQD_ACC: src_zero = 1'b0;
         OP_MSC: subtract = 1'b1;
         OP_LOAD: begin
            src_zero = 1'b1;
            b_data   = shifted_data_i;
         end
         OP_ADD_DATA: b_data = shifted_data_i;
         OP_ADD_ACC: b_data = other;
         OP_SUB_ACC: begin
            b_data   = other;
            subtract = 1'b1;
         end
         OP_NEG: begin
            src_zero = 1'b1;
            b_data   = tgt;
            subtract = 1'b1;
         end
         OP_CLR: begin
            src_zero = 1'b1;
            b_data   = '0;
         end
         OP_NOP, OP_MCU_MUL: b_data = '0;
         default: b_data = '0;
      endcase
   end

   // adder, overflow detection and saturation in one cycle
   always_comb begin
      src    = src_zero ? '0 : tgt;
      b_eff  = subtract ? ~b_data : b_data;
      // carry in: zero for add, one (borrow inactive, high) for subtract
      sum40  = src + b_eff + {39'h0, subtract};
      ovf39  = (src[ACC_W-1] == b_eff[ACC_W-1]) && (sum40[ACC_W-1] != src[ACC_W-1]);
      true_neg = ovf39 ? ~sum40[ACC_W-1] : sum40[ACC_W-1];
      over31 = ovf39 || !all_same(sum40[ACC_W-1:NORM_TOP], 1'b0);
      result   = sum40;
      clip_set = 1'b0;
      if (clip_en && clip_width_select && ovf39) begin
         result   = true_neg ? SUPER_MIN : SUPER_MAX;
         clip_set = 1'b1;
      end else if (clip_en && !clip_width_select && over31) begin
         result   = true_neg ? NORM_MIN : NORM_MAX;
         clip_set = 1'b1;
      end else if (!clip_en) begin
         clip_set = ovf39;
      end
      // normal saturation leaves the guard bits unused
      guard_next = !(clip_en && !clip_width_select) &&
                   !all_same(result[ACC_W-1:NORM_TOP], 1'b1);
      trap_next = 1'b0;
      if (pass) begin
         if (guard_next && !(acc_sel_i ? accum_b_guard_overflow_reg
                                       : accum_a_guard_overflow_reg) &&
             trap_en_reg[acc_sel_i ? TRP_GB : TRP_GA])
            trap_next = 1'b1;
         if (!clip_en && clip_set && trap_en_reg[TRP_WRAP])
            trap_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_a_reg <= '0;
         accum_b_reg <= '0;
      end else if (pass) begin
         if (acc_sel_i)
            accum_b_reg <= result;
         else
            accum_a_reg <= result;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_a_guard_overflow_reg <= 1'b0;
         accum_b_guard_overflow_reg <= 1'b0;
      end else if (pass) begin
         if (acc_sel_i)
            accum_b_guard_overflow_reg <= guard_next;
         else
            accum_a_guard_overflow_reg <= guard_next;
      end
   end

   // status clear: writing zero to a clip bit or to the combined bit
   assign bus_req = cyc_i && stb_i;
   assign wr_stb  = ce_i && bus_req && we_i && ack_reg;
   assign clr_a = wr_stb && (adr_i == ADR_STAT) && sel_i[1] &&
                  (!dat_i[ST_CA] || !dat_i[ST_CANY]);
   assign clr_b = wr_stb && (adr_i == ADR_STAT) && sel_i[1] &&
                  (!dat_i[ST_CB] || !dat_i[ST_CANY]);

   // a set arriving with a clear wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         accum_a_clip_flag_reg <= 1'b0;
         accum_b_clip_flag_reg <= 1'b0;
      end else if (ce_i) begin
         accum_a_clip_flag_reg <= (pass && !acc_sel_i && clip_set) ||
                                  (accum_a_clip_flag_reg && !clr_a);
         accum_b_clip_flag_reg <= (pass && acc_sel_i && clip_set) ||
                                  (accum_b_clip_flag_reg && !clr_b);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         trap_reg <= 1'b0;
      else if (ce_i)
         trap_reg <= trap_next;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mcu_prod_reg  <= '0;
         mcu_valid_reg <= 1'b0;
      end else if (ce_i) begin
         mcu_valid_reg <= op_valid_i && (op == OP_MCU_MUL);
         if (op_valid_i && (op == OP_MCU_MUL))
            mcu_prod_reg <= mcu_next;
      end
   end

   // configuration registers, taken at the edge the master sees ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_control_reg <= CTRL_RESET;
         trap_en_reg      <= '0;
      end else if (wr_stb) begin
         if (adr_i == ADR_CTRL)
            core_control_reg <= merge16(core_control_reg, dat_i[15:0], sel_i[1:0],
                                        CTRL_MASK);
         if (adr_i == ADR_TRAP)
            trap_en_reg <= merge16(trap_en_reg, dat_i[15:0], sel_i[1:0], TRAP_MASK);
      end
   end

   always_comb begin
      rd_word = '0;
      unique case (adr_i)
         ADR_CTRL: rd_word[15:0] = core_control_reg;
         ADR_TRAP: rd_word[15:0] = trap_en_reg;
         ADR_STAT: begin
            rd_word[ST_GA]   = accum_a_guard_overflow_reg;
            rd_word[ST_GB]   = accum_b_guard_overflow_reg;
            rd_word[ST_CA]   = accum_a_clip_flag_reg;
            rd_word[ST_CB]   = accum_b_clip_flag_reg;
            rd_word[ST_GANY] = accum_a_guard_overflow_reg || accum_b_guard_overflow_reg;
            rd_word[ST_CANY] = accum_a_clip_flag_reg || accum_b_clip_flag_reg;
         end
         ADR_ACCUM_A_LO: rd_word = accum_a_reg[31:0];
         ADR_ACCUM_A_HI: rd_word[BYTE_W-1:0] = accum_a_reg[ACC_W-1:32];
         ADR_ACCUM_B_LO: rd_word = accum_b_reg[31:0];
         ADR_ACCUM_B_HI: rd_word[BYTE_W-1:0] = accum_b_reg[ACC_W-1:32];
         ADR_MCU: rd_word = mcu_prod_reg;
         default: rd_word = '0; // unmapped reads as zero, still acked
      endcase
   end

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= '0;
      end else if (ce_i) begin
         ack_reg <= bus_req && !ack_reg;
         if (bus_req && !ack_reg)
            dat_reg <= rd_word;
      end
   end

   assign dat_o                   = dat_reg;
   assign ack_o                   = ack_reg;
   assign mcu_prod_o              = mcu_prod_reg;
   assign mcu_prod_valid_o        = mcu_valid_reg;
   assign acc_a_o                 = accum_a_reg;
   assign acc_b_o                 = accum_b_reg;
   assign trap_o                  = trap_reg;
   assign round_style_o           = core_control_reg[CTL_RND];
   assign mem_write_clip_enable_o = core_control_reg[CTL_MEMCLIP];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_bus_start;
      ce_i && bus_req && !ack_o;
   endsequence
   sequence s_bus_ack;
      ack_o ##1 (!ack_o || !ce_i);
   endsequence

   a_bus_ack_pulse: assert property (s_bus_start |=> s_bus_ack)
      else $error("wishbone ack not a single pulse");
   a_normal_no_guard: assert property (pass && !acc_sel_i && core_control_reg[CTL_CLIPA]
      && !clip_width_select |=> !accum_a_guard_overflow_reg)
      else $error("guard flag set under normal saturation");
   a_clip_stays_set: assert property (ce_i && accum_a_clip_flag_reg && !clr_a
      |=> accum_a_clip_flag_reg)
      else $error("clip flag dropped without clear");
   a_wrap_no_clamp: assert property (pass && !clip_en && ovf39 && !acc_sel_i
      |=> accum_a_reg == $past(sum40) && accum_a_clip_flag_reg)
      else $error("wrapped value altered or clip not set");
   a_normal_clamp_pos: assert property (pass && !acc_sel_i && clip_en
      && !clip_width_select && over31 && !true_neg |=> accum_a_reg == NORM_MAX)
      else $error("normal clamp value wrong");
   a_super_clamp_neg: assert property (pass && acc_sel_i && clip_en && clip_width_select
      && ovf39 && true_neg |=> accum_b_reg == SUPER_MIN && accum_b_clip_flag_reg)
      else $error("super clamp value wrong");
   a_guard_trap: assert property (pass && !acc_sel_i && guard_next
      && !accum_a_guard_overflow_reg && trap_en_reg[TRP_GA] |=> trap_o)
      else $error("guard trap missing");
   a_mcu_byte_width: assert property (ce_i && op_valid_i && op == OP_MCU_MUL && mcu_byte_i
      |=> mcu_prod_valid_o && mcu_prod_o[31:16] == 16'h0000)
      else $error("byte product wider than 16 bits");
   a_any_clip_read: assert property ((s_bus_start and adr_i == ADR_STAT) |=>
      dat_o[ST_CANY] == ($past(accum_a_clip_flag_reg) || $past(accum_b_clip_flag_reg)))
      else $error("combined clip bit wrong");
   a_wrap_trap: assert property (pass && !clip_en && clip_set && trap_en_reg[TRP_WRAP]
      |=> trap_o)
      else $error("wrap trap missing");
   a_b_no_guard: assert property (pass && acc_sel_i && core_control_reg[CTL_CLIPB]
      && !clip_width_select |=> !accum_b_guard_overflow_reg)
      else $error("guard flag b set under normal saturation");
   a_acc_hold: assert property (!pass |=> accum_a_reg == $past(accum_a_reg)
      && accum_b_reg == $past(accum_b_reg))
      else $error("accumulator changed without a pass");
   a_clip_sets_b: assert property (pass && acc_sel_i && clip_set
      |=> accum_b_clip_flag_reg)
      else $error("clip flag b not set on overflow");

endmodule : dsm_engine

// >>> test/dsm_decoder_model.sv
`timescale 1ns/10ps
module dsm_decoder_model
   import dsm_pkg::*;
(
   // clock
   input  wire logic              clk_i,
   // instruction fields
   output logic                   op_valid_o,
   output logic      [3:0]        op_o,
   output logic                   acc_sel_o,
   output logic      [OPND_W-1:0] opnd_x_o,
   output logic      [OPND_W-1:0] opnd_y_o,
   output logic      [ACC_W-1:0]  shifted_data_o,
   output logic                   mcu_byte_o,
   output logic                   mcu_x_signed_o,
   output logic                   mcu_y_signed_o
);
   initial begin
      {op_valid_o, op_o, acc_sel_o, mcu_byte_o, mcu_x_signed_o, mcu_y_signed_o} = '0;
      {opnd_x_o, opnd_y_o, shifted_data_o} = '0;
   end

   // one instruction per call, launched after an edge and held for one cycle
   task automatic issue(input logic [3:0] o, input logic s, input logic [15:0] x, y,
                        input logic [39:0] sh, input logic b, xs, ys);
      @(posedge clk_i);
      op_valid_o     <= 1'b1;
      op_o           <= o;
      acc_sel_o      <= s;
      opnd_x_o       <= x;
      opnd_y_o       <= y;
      shifted_data_o <= sh;
      mcu_byte_o     <= b;
      mcu_x_signed_o <= xs;
      mcu_y_signed_o <= ys;
   endtask : issue

   // stall: data lines keep toggling so a stale operand never matches by luck
   task automatic idle();
      @(posedge clk_i);
      op_valid_o     <= 1'b0;
      op_o           <= 4'h0;
      opnd_x_o       <= ~opnd_x_o;
      opnd_y_o       <= ~opnd_y_o;
      shifted_data_o <= ~shifted_data_o;
   endtask : idle
endmodule : dsm_decoder_model

// >>> test/dsm_engine_tb.sv
`timescale 1ns/10ps
module dsm_engine_tb
   import dsm_pkg::*;
;
   localparam logic [15:0] CFGS [5] = '{16'h0022, 16'h00C0, 16'h00D0, 16'h1041, 16'h0093};
   logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, op_taken;
   logic        op_valid_i, acc_sel_i, mcu_byte_i, mcu_x_signed_i, mcu_y_signed_i;
   logic        mcu_prod_valid_o, trap_o, round_style_o, mem_write_clip_enable_o;
   logic [3:0]  op_i, sel_i;
   logic [4:0]  adr_i;
   logic [15:0] opnd_x_i, opnd_y_i, ctl;
   logic [31:0] dat_i, dat_o, mcu_prod_o;
   logic [39:0] shifted_data_i, acc_a_o, acc_b_o;
   logic [39:0] acc [2];
   logic [2:0]  trp;
   logic [1:0]  guard, clip;
   logic [63:0] rd_q [$];
   logic [80:0] acc_q [$];
   logic [31:0] mcu_q [$];
   logic [63:0] rn;
   logic [80:0] an;
   int          mismatches, n_compared;

   dsm_engine u_dsm_engine (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .op_valid_i(op_valid_i), .op_i(op_i), .acc_sel_i(acc_sel_i), .opnd_x_i(opnd_x_i),
      .opnd_y_i(opnd_y_i), .shifted_data_i(shifted_data_i), .mcu_byte_i(mcu_byte_i),
      .mcu_x_signed_i(mcu_x_signed_i), .mcu_y_signed_i(mcu_y_signed_i),
      .mcu_prod_o(mcu_prod_o), .mcu_prod_valid_o(mcu_prod_valid_o), .acc_a_o(acc_a_o),
      .acc_b_o(acc_b_o), .trap_o(trap_o), .round_style_o(round_style_o),
      .mem_write_clip_enable_o(mem_write_clip_enable_o));

   dsm_decoder_model u_dsm_decoder_model (
      .clk_i(clk_i), .op_valid_o(op_valid_i), .op_o(op_i), .acc_sel_o(acc_sel_i),
      .opnd_x_o(opnd_x_i), .opnd_y_o(opnd_y_i), .shifted_data_o(shifted_data_i),
      .mcu_byte_o(mcu_byte_i), .mcu_x_signed_o(mcu_x_signed_i),
      .mcu_y_signed_o(mcu_y_signed_i));

   initial clk_i = 1'b0;
   always #4 clk_i = ~clk_i;

   // the whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      summarize();
   end

   task automatic chk(input logic [39:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      sel_i <= s;
      dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
         chk(40'h0, 40'h1, "no bus answer");
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
   endtask : wb

   task automatic rd(input logic [4:0] a, input logic [31:0] e, m = 32'hFFFF_FFFF);
      rd_q.push_back({m, e});
      wb(1'b0, a, 4'hF, 32'h0);
   endtask : rd

   task automatic rd_stat();
      rd(ADR_STAT, {16'h0, guard[0], guard[1], clip[0], clip[1], |guard, |clip, 10'h0});
   endtask : rd_stat

   task automatic clr_stat(input logic [15:0] d);
      wb(1'b1, ADR_STAT, 4'h2, {16'h0, d});
      if (!d[ST_CA] || !d[ST_CANY])
         clip[0] = 1'b0;
      if (!d[ST_CB] || !d[ST_CANY])
         clip[1] = 1'b0;
      rd_stat();
   endtask : clr_stat

   task automatic cfg(input logic [15:0] c, input logic [2:0] t);
      wb(1'b1, ADR_CTRL, 4'h3, {16'h0, c});
      wb(1'b1, ADR_TRAP, 4'h3, {29'h0, t});
      ctl = c & CTRL_MASK;
      trp = t;
      rd(ADR_TRAP, {29'h0, t});
      @(negedge clk_i);
      chk(40'(round_style_o), 40'(ctl[CTL_RND]), "round style");
      chk(40'(mem_write_clip_enable_o), 40'(ctl[CTL_MEMCLIP]), "memory clip enable");
   endtask : cfg

   function automatic logic signed [63:0] ext(input logic [15:0] v, input logic u);
      return u ? {48'h0, v} : {{48{v[15]}}, v};
   endfunction : ext

   task automatic op(input logic [3:0] o, input logic s, input logic [15:0] x, y,
                     input logic [39:0] sh);
      logic signed [63:0] px, py, src, sum;
      logic [39:0]        r;
      logic               sat, c, t, g;
      px = ext(x, ctl[CTL_SIGN]);
      py = (o == OP_SQD || o == OP_SQD_ACC) ? px : ext(y, ctl[CTL_SIGN]);
      px = ctl[CTL_INT] ? px * py : (px * py) <<< 1;
      px = {{31{px[32]}}, px[32:0]};
      src = {{24{acc[s][39]}}, acc[s]};
      case (o)
         OP_MPY, OP_SQD:     sum = px;
         OP_MPY_NEG:         sum = -px;
         OP_MAC, OP_SQD_ACC: sum = src + px;
         OP_MSC:             sum = src - px;
         OP_LOAD:            sum = {{24{sh[39]}}, sh};
         OP_ADD_DATA:        sum = src + {{24{sh[39]}}, sh};
         OP_ADD_ACC:         sum = src + {{24{acc[!s][39]}}, acc[!s]};
         OP_SUB_ACC:         sum = src - {{24{acc[!s][39]}}, acc[!s]};
         OP_NEG:             sum = -src;
         default:            sum = 64'sh0;
      endcase
      sat = s ? ctl[CTL_CLIPB] : ctl[CTL_CLIPA];
      c = sum > 64'sh7F_FFFF_FFFF || sum < -64'sh80_0000_0000;
      r = sum[39:0];
      t = 1'b0;
      if (sat && !ctl[CTL_WIDTH])
         c = sum > 64'sh7FFF_FFFF || sum < -64'sh8000_0000;
      if (sat && c)
         r = sum < 0 ? (ctl[CTL_WIDTH] ? SUPER_MIN : NORM_MIN)
                     : (ctl[CTL_WIDTH] ? SUPER_MAX : NORM_MAX);
      else if (c)
         t = trp[TRP_WRAP];
      g = !(&r[39:32] || ~|r[39:32]) && !(sat && !ctl[CTL_WIDTH]);
      t = t || (g && !guard[s] && trp[s]);
      guard[s] = g;
      clip[s] = clip[s] | c;
      acc[s] = r;
      acc_q.push_back({acc[0], acc[1], t});
      u_dsm_decoder_model.issue(o, s, x, y, sh, 1'b0, 1'b0, 1'b0);
   endtask : op

   task automatic mcu(input logic [15:0] x, y, input logic b, xs, ys);
      logic signed [63:0] p;
      p = ext(x, !xs) * ext(y, !ys);
      mcu_q.push_back(b ? {16'h0, 16'(x[7:0]) * 16'(y[7:0])} : p[31:0]);
      u_dsm_decoder_model.issue(OP_MCU_MUL, 1'b0, x, y, 40'h0, b, xs, ys);
   endtask : mcu

   always @(posedge clk_i)
      op_taken <= !rst_i && ce_i && op_valid_i && op_i != OP_NOP && op_i != OP_MCU_MUL;

   // each result is matched to the oldest note half a cycle after it lands
   always @(negedge clk_i) begin
      if (ack_o === 1'b1 && !we_i && rd_q.size() > 0) begin
         rn = rd_q.pop_front();
         chk(40'(dat_o & rn[63:32]), 40'(rn[31:0]), "register read");
      end
      if (op_taken === 1'b1 && acc_q.size() > 0) begin
         an = acc_q.pop_front();
         chk(acc_a_o, an[80:41], "accumulator a");
         chk(acc_b_o, an[40:1], "accumulator b");
         chk(40'(trap_o), 40'(an[0]), "trap");
      end
      if (mcu_prod_valid_o === 1'b1 && mcu_q.size() > 0)
         chk(40'(mcu_prod_o), 40'(mcu_q.pop_front()), "mcu product");
   end

   initial begin
      void'($urandom(30464));
      {rst_i, ce_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {2'b11, 44'h0};
      {guard, clip, trp, op_taken} = '0;
      acc = '{40'h0, 40'h0};
      ctl = CTRL_RESET;
      mismatches = 0;
      n_compared = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_CTRL, {16'h0, CTRL_RESET});
      rd(ADR_TRAP, 32'h0);
      rd_stat();
      rd(ADR_ACCUM_B_LO, 32'h0);
      rd(5'h02, 32'h0);
      wb(1'b1, 5'h02, 4'hF, 32'hFFFF_FFFF);
      wb(1'b1, ADR_CTRL, 4'h1, 32'hFFFF_FFFF);
      ctl = (CTRL_RESET & 16'hFF00) | (CTRL_MASK & 16'h00FF);
      rd(ADR_CTRL, {16'h0, ctl});
      for (int i = 0; i < 5; i++) begin
         cfg(CFGS[i], 3'(i + 3));
         for (int k = 0; k < 48; k++) begin
            op(4'(k % 12 + 1), 1'($urandom_range(1)), 16'($urandom), 16'($urandom),
               {8'($urandom), 32'($urandom)});
            if ($urandom_range(3) == 0)
               u_dsm_decoder_model.idle();
         end
         u_dsm_decoder_model.idle();
         rd_stat();
         rd(ADR_ACCUM_A_LO, acc[0][31:0]);
         rd(ADR_ACCUM_B_HI, {24'h0, acc[1][39:32]}, 32'h0000_00FF);
         clr_stat(i[0] ? 16'hFBFF : 16'hDFFF);
      end
      for (int k = 0; k < 12; k++)
         mcu(16'($urandom), 16'($urandom), 1'(k % 3 == 0), 1'(k % 2), 1'(k / 2 % 2));
      u_dsm_decoder_model.idle();
      // with the clock enable low the instruction must leave no trace
      @(posedge clk_i);
      ce_i <= 1'b0;
      u_dsm_decoder_model.issue(OP_LOAD, 1'b0, 16'h0, 16'h0, 40'h12_3456_789A,
                                1'b0, 1'b0, 1'b0);
      u_dsm_decoder_model.idle();
      ce_i <= 1'b1;
      rd(ADR_ACCUM_A_LO, acc[0][31:0]);
      chk(40'(acc_q.size() + mcu_q.size() + rd_q.size()), 40'h0, "results missing");
      summarize();
   end
endmodule : dsm_engine_tb
